// >>> hdl/sbc_pkg.sv
/*
 Shared constants and types for the register-access layer behind the
 16-bit serial port: addresses, field positions, reset values, modes.
 Assumes one system clock domain; serial pins are synchronised inside.
*/
`default_nettype none

package sbc_pkg;

    // Frame layout, least significant bit first on the wire
    localparam int unsigned FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'd16;
    localparam logic [4:0] ADDR_DONE_CNT = 5'd7;

    // Register ranges
    localparam logic [6:0] CTRL_LAST = 7'h1E;
    localparam logic [6:0] STAT_FIRST = 7'h40;
    localparam logic [6:0] STAT_LAST = 7'h7E;
    localparam int unsigned NCTRL = 31;

    // Clearable status registers, index order used everywhere
    localparam int unsigned NSTAT = 9;
    localparam int unsigned SI_SUP2 = 0;
    localparam int unsigned SI_SUP1 = 1;
    localparam int unsigned SI_THERM = 2;
    localparam int unsigned SI_DEV = 3;
    localparam int unsigned SI_BUS = 4;
    localparam int unsigned SI_WK1 = 5;
    localparam int unsigned SI_WK2 = 6;
    localparam int unsigned SI_HSOC = 7;
    localparam int unsigned SI_HSOL = 8;
    localparam logic [6:0] STAT_ADDR [NSTAT] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44,
                                                 7'h46, 7'h47, 7'h54, 7'h55};
    localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
    localparam logic [6:0] ADDR_FAMILY_ID = 7'h7E;

    // Control registers touched by mode changes
    localparam logic [6:0] ADDR_SUPPLY_CTRL = 7'h00;
    localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
    localparam logic [6:0] ADDR_BUS_CTRL = 7'h03;
    localparam logic [6:0] ADDR_HS_CTRL_1 = 7'h14;
    localparam logic [6:0] ADDR_HS_CTRL_2 = 7'h15;
    localparam logic [7:0] SECOND_SUPPLY_MASK = 8'h03;
    localparam int unsigned MODE_LSB = 6;
    localparam int unsigned CAN_LSB = 0;
    localparam int unsigned LIN_LSB = 2;
    localparam logic [1:0] XCVR_OFF = 2'h0;
    localparam logic [1:0] XCVR_WAKE = 2'h1;
    localparam int unsigned CMD_FAIL_BIT = 3;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_SLEEP   = 2'h1,
        MODE_STOP    = 2'h2,
        MODE_RESTART = 2'h3
    } sbc_mode_t;

    typedef enum logic [1:0] {
        FR_IDLE  = 2'b00,
        FR_SHIFT = 2'b01,
        FR_END   = 2'b11
    } sbc_frame_state_t;

    typedef struct packed {
        logic chip_select_low;
        logic sclk;
        logic sdi;
    } sbc_pins_t;

    typedef struct packed {
        logic [7:0] data;
        logic       wr;
        logic [6:0] addr;
    } sbc_frame_t;

endpackage

`default_nettype wire

// >>> hdl/sbc_spi_regs.sv
/*
 Register-access layer of the serial port: frame capture, status
 summary, read/write and read/clear decode, mode-driven control updates.
 Assumes mode, restart and fault inputs come from logic on clk.
*/
// Functional notes
// - Address sits in frame bits six..zero
// - Data byte sits in frame bits fifteen..eight
// - Control range: bit7 low reads, high writes
// - Status range: bit7 high clears the byte
// - Wake level and identifier ignore clears
// - Whole byte written, cleared, read at once
// - Status bits stay until cleared by command
// - Frames ignored during restart mode
// - Status byte returned in same frame
// - Control: old byte now, new next frame
// - Summary bit set while register nonzero
// - Summary bits 0..3 map four status registers
// - Summary bit 4 ORs both wake registers
// - Summary bits 5..7 map remaining status registers
// - Wake level register excluded from summary
// - Mode bits show the mode entered
// - Low power keeps diagnosis, fail output held
// - Stop keeps transceiver control bits
// - Sleep forces active transceivers to wake-capable
// - Faulted switch turns off, no wake
// - Restart clears switch and second-supply config
// - Sample on falling, shift after rising edge
// - Release output as select rises, then interpret
// - Bad nonzero clock count discarded, error flagged next
// - Prohibited writes ignored, command-fail bit set
`default_nettype none

module sbc_spi_regs
    import sbc_pkg::*;
#(
    parameter logic [7:0] FAMILY_ID = 8'hA5 // Arbitrary identifier value
) (
    input  wire logic                             clk,
    input  wire logic                             rst_b,
    input  wire sbc_pkg::sbc_pins_t               spi_pins,
    output var  logic                             sdo,
    output var  logic                             sdo_oe,
    input  wire logic                             restart_mode,
    input  wire logic                             mode_change,
    input  wire sbc_pkg::sbc_mode_t               mode_entered,
    input  wire logic                             write_prohibited,
    input  wire logic [sbc_pkg::NSTAT-1:0][7:0]   stat_event,
    input  wire logic [7:0]                       wake_pin_level,
    input  wire logic                             fail_trigger,
    input  wire logic                             fail_clear,
    output var  logic [sbc_pkg::NCTRL-1:0][7:0]   ctrl_q,
    output var  logic [7:0]                       hs_drive_enable,
    output var  logic                             fail_output
);
    import sbc_pkg::*;

    sbc_pins_t        pins_s;
    logic             sclk_d;
    logic             cs_d;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             cs_fall;
    logic             cs_rise;
    sbc_frame_state_t state;
    logic [4:0]       bit_cnt;
    logic [15:0]      rx;
    logic [15:0]      next_rx;
    logic [15:0]      tx;
    logic             clk_bad;
    logic             restart_seen;
    logic             err_pending;
    sbc_frame_t       frame;
    logic             frame_ok;
    logic             do_write;
    logic             do_clear;
    logic             cmd_fail;
    logic [NSTAT-1:0][7:0] stat;
    logic [7:0]       summary;
    logic             restart_entry;

    // Pins cross into clk through three stages each
    sbc_sync3 #(
        .WIDTH(3)
    ) u_sync (
        .clk  (clk),
        .rst_b(rst_b),
        .d    (spi_pins),
        .q    (pins_s)
    );

    // Edge detection on the filtered pins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_d <= 1'b1;
            cs_d   <= 1'b1;
        end
        else
        begin
            sclk_d <= pins_s.sclk;
            cs_d   <= pins_s.chip_select_low;
        end
    end

    assign sclk_rise = pins_s.sclk & ~sclk_d;
    assign sclk_fall = ~pins_s.sclk & sclk_d;
    assign cs_fall   = ~pins_s.chip_select_low & cs_d;
    assign cs_rise   = pins_s.chip_select_low & ~cs_d;
    assign next_rx   = {pins_s.sdi, rx[15:1]}; // LSB arrives first
    assign frame     = sbc_frame_t'(rx);

    // Frame sequencing: idle, shifting, interpretation
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= FR_IDLE;
        else
        begin
            case (state)
                FR_IDLE:
                    if (cs_fall)
                        state <= FR_SHIFT;
                FR_SHIFT:
                    if (cs_rise)
                        state <= FR_END;
                FR_END:
                    state <= FR_IDLE;
                default:
                    state <= FR_IDLE;
            endcase
        end
    end

    // Input shift on falling clock edges, count saturates
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx      <= WORD_ZERO;
            bit_cnt <= 5'd0;
        end
        else if (state == FR_IDLE && cs_fall)
        begin
            rx      <= WORD_ZERO;
            bit_cnt <= 5'd0;
        end
        else if (state == FR_SHIFT && sclk_fall)
        begin
            rx <= next_rx;
            if (bit_cnt != 5'd31)
                bit_cnt <= bit_cnt + 5'd1;
        end
    end

    // Clock high at either select edge spoils the frame
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clk_bad <= 1'b0;
        else if (state == FR_IDLE && cs_fall)
            clk_bad <= pins_s.sclk;
        else if (state == FR_SHIFT && cs_rise && pins_s.sclk)
            clk_bad <= 1'b1;
    end

    // Any overlap with restart spoils the frame
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            restart_seen <= 1'b0;
        else if (state == FR_IDLE && cs_fall)
            restart_seen <= restart_mode;
        else if (state == FR_SHIFT && restart_mode)
            restart_seen <= 1'b1;
    end

    // Frame accepted only with exactly sixteen clocks, no restart
    assign frame_ok = (state == FR_END) && (bit_cnt == FRAME_LEN) && !clk_bad && !restart_seen;
    assign cmd_fail = frame_ok && frame.wr && (frame.addr <= CTRL_LAST)
                      && (write_prohibited || rx == WORD_ZERO || rx == WORD_ONES);
    assign do_write = frame_ok && frame.wr && (frame.addr <= CTRL_LAST) && !cmd_fail;
    assign do_clear = frame_ok && frame.wr && (frame.addr >= STAT_FIRST);

    // Error held until shown at the start of the next frame
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            err_pending <= 1'b0;
        else if (state == FR_END && bit_cnt != 5'd0 && !frame_ok)
            err_pending <= 1'b1;
        else if (state == FR_END && (clk_bad || restart_seen))
            err_pending <= 1'b1;
        else if (state == FR_IDLE && cs_fall)
            err_pending <= 1'b0;
    end

    // Byte returned for an address, whole byte at a time
    function automatic logic [7:0] read_byte(input logic [6:0] a,
                                              input logic [NCTRL-1:0][7:0] c,
                                              input logic [NSTAT-1:0][7:0] s);
        logic [7:0] r;
        r = 8'h00;
        if (a <= CTRL_LAST)
            r = c[a[4:0]];
        else if (a == ADDR_WAKE_LEVEL)
            r = wake_pin_level;
        else if (a == ADDR_FAMILY_ID)
            r = FAMILY_ID;
        for (int k = 0; k < NSTAT; k++)
            if (a == STAT_ADDR[k])
                r = s[k];
        return r;
    endfunction

    // Output shift: error first, summary, then addressed byte
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx  <= WORD_ZERO;
            sdo <= 1'b0;
        end
        else if (restart_mode)
            sdo <= 1'b1; // Output held high while restarting
        else if (state == FR_IDLE && cs_fall)
        begin
            tx  <= {8'h00, summary};
            sdo <= err_pending;
        end
        else if (state == FR_SHIFT && sclk_rise)
        begin
            sdo <= tx[0];
            tx  <= {1'b0, tx[15:1]};
        end
        else if (state == FR_SHIFT && sclk_fall && bit_cnt == ADDR_DONE_CNT)
            tx[7:0] <= read_byte(next_rx[14:8], ctrl_q, stat);
    end

    // Output driven only between select edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sdo_oe <= 1'b0;
        else if (state == FR_IDLE && cs_fall)
            sdo_oe <= 1'b1;
        else if (cs_rise)
            sdo_oe <= 1'b0;
    end

    // Clearable status registers; an event in the clear cycle survives
    genvar i;
    generate
        for (i = 0; i < NSTAT; i++)
        begin : g_stat
            logic [7:0] hw_set;
            logic       clr;
            assign hw_set = stat_event[i] | ((i == SI_DEV && cmd_fail) ? 8'h01 << CMD_FAIL_BIT : 8'h00);
            assign clr    = do_clear && frame.addr == STAT_ADDR[i];
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    stat[i] <= STAT_RESET;
                else
                    stat[i] <= (clr ? 8'h00 : stat[i]) | hw_set;
            end
        end
    endgenerate

    // Summary: one bit per status register, wake pair merged
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            summary <= 8'h00;
        else
        begin
            summary[0] <= |stat[SI_SUP1];
            summary[1] <= |stat[SI_THERM];
            summary[2] <= |stat[SI_DEV];
            summary[3] <= |stat[SI_BUS];
            summary[4] <= |(stat[SI_WK1] | stat[SI_WK2]);
            summary[5] <= |stat[SI_SUP2];
            summary[6] <= |stat[SI_HSOC];
            summary[7] <= |stat[SI_HSOL];
        end
    end

    assign restart_entry = mode_change && mode_entered == MODE_RESTART;

    // Control registers; mode changes override a same-cycle write
    generate
        for (i = 0; i < NCTRL; i++)
        begin : g_ctrl
            logic [7:0] next_ctrl;
            always_comb
            begin
                next_ctrl = ctrl_q[i];
                if (do_write && frame.addr[4:0] == 5'(i))
                    next_ctrl = frame.data;
                if (mode_change && 7'(i) == ADDR_MODE_CTRL)
                    next_ctrl[MODE_LSB +: 2] = mode_entered;
                if (mode_change && mode_entered == MODE_SLEEP && 7'(i) == ADDR_BUS_CTRL)
                begin
                    if (next_ctrl[CAN_LSB +: 2] != XCVR_OFF && next_ctrl[CAN_LSB +: 2] != XCVR_WAKE)
                        next_ctrl[CAN_LSB +: 2] = XCVR_WAKE;
                    if (next_ctrl[LIN_LSB +: 2] != XCVR_OFF && next_ctrl[LIN_LSB +: 2] != XCVR_WAKE)
                        next_ctrl[LIN_LSB +: 2] = XCVR_WAKE;
                end
                if (restart_entry && (7'(i) == ADDR_HS_CTRL_1 || 7'(i) == ADDR_HS_CTRL_2))
                    next_ctrl = 8'h00;
                if (restart_entry && 7'(i) == ADDR_SUPPLY_CTRL)
                    next_ctrl = next_ctrl & ~SECOND_SUPPLY_MASK;
            end
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    ctrl_q[i] <= CTRL_RESET;
                else
                    ctrl_q[i] <= next_ctrl;
            end
        end
    endgenerate

    // Switch drive gated by its own fault, no wake request raised
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            hs_drive_enable <= 8'h00;
        else
            hs_drive_enable <= ctrl_q[ADDR_HS_CTRL_1[4:0]] & ~(stat[SI_HSOC] | stat[SI_HSOL]);
    end

    // Fail output ignores mode changes; only its own clear releases it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fail_output <= 1'b0;
        else if (fail_trigger)
            fail_output <= 1'b1;
        else if (fail_clear)
            fail_output <= 1'b0;
    end
endmodule

`default_nettype wire

// >>> hdl/sbc_sync3.sv
/*
 Three-stage synchroniser with agreement filter for asynchronous pins.
 Assumes each bit is an independent level; no bus coherency is implied.
*/
`default_nettype none

module sbc_sync3 #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // First stage feeds only the second, so metastability stays contained
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A bit changes only once the two later stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    q[i] <= 1'b1;
                else if (s2[i] == s3[i])
                    q[i] <= s3[i];
            end
        end
    endgenerate
endmodule

`default_nettype wire

// >>> verification/sbc_host_model.sv
/*
 Host controller model: drives chip select, serial clock and data-in.
 Assumes the device output is high impedance whenever sdo_oe is low.
*/
`default_nettype none

module sbc_host_model
    import sbc_pkg::*;
(
    input  wire logic      clk,
    output var  sbc_pins_t pins,
    input  wire logic      sdo,
    input  wire logic      sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 8; // 40 ns half period of an 80 ns link clock
    logic line;

    // Released output shows as Z, never as a stale bit
    assign line = sdo_oe ? sdo : 1'bz;

    initial pins = '{chip_select_low: 1'b1, sclk: 1'b0, sdi: 1'b1};

    // One frame of n clocks; clock idles low at both select edges
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx, output logic err);
        rx = WORD_ZERO;
        pins.chip_select_low <= 1'b0;
        repeat (HALF) @(posedge clk);
        err = line;
        for (int i = 0; i < n; i++)
        begin
            // Data moves on the rise, settled by the fall
            repeat (HALF) @(posedge clk);
            pins.sclk <= 1'b1;
            pins.sdi <= w[i];
            repeat (HALF) @(posedge clk);
            rx[i] = line;
            pins.sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        pins.chip_select_low <= 1'b1;
        pins.sdi <= ~pins.sdi; // Data line inverted once after the frame, then held while idle
        repeat (3 * HALF) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// >>> verification/sbc_spi_regs_properties.sv
/*
 Concurrent checks on the ports of the serial register-access layer.
 Assumes one clk domain and the async active-low rst_b of the design.
*/
`default_nettype none

module sbc_spi_regs_checker
    import sbc_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           rst_b,
    input  wire sbc_pkg::sbc_pins_t             spi_pins,
    input  wire logic                           sdo,
    input  wire logic                           sdo_oe,
    input  wire logic                           restart_mode,
    input  wire logic                           mode_change,
    input  wire sbc_pkg::sbc_mode_t             mode_entered,
    input  wire logic                           write_prohibited,
    input  wire logic [sbc_pkg::NSTAT-1:0][7:0] stat_event,
    input  wire logic [7:0]                     wake_pin_level,
    input  wire logic                           fail_trigger,
    input  wire logic                           fail_clear,
    input  wire logic [sbc_pkg::NCTRL-1:0][7:0] ctrl_q,
    input  wire logic [7:0]                     hs_drive_enable,
    input  wire logic                           fail_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Output pin released and driven around chip select
    AST_OE_IDLE: assert property (spi_pins.chip_select_low [*8] |-> !sdo_oe)
        else $error("data output driven while deselected");
    AST_OE_SELECT: assert property ((!spi_pins.chip_select_low) [*8] ##0 !restart_mode |-> sdo_oe)
        else $error("data output not driven during frame");
    AST_RESTART_SDO: assert property (restart_mode [*4] ##0 sdo_oe |-> sdo)
        else $error("data output not high in restart");
    // Commits only land after the frame closes
    AST_CTRL_QUIET: assert property ((!spi_pins.chip_select_low) [*8] ##0 !mode_change |=> $stable(ctrl_q))
        else $error("control changed inside a frame");
    AST_RESTART_HOLD: assert property (restart_mode [*2] ##0 !mode_change |=> $stable(ctrl_q))
        else $error("control changed in restart");
    AST_HS_GATE: assert property (1'b1 |=> (hs_drive_enable & ~$past(ctrl_q[ADDR_HS_CTRL_1])) == 8'h00)
        else $error("switch driven without configuration");
    // Mode-change edits
    AST_MODE_BITS: assert property (mode_change |=> ctrl_q[ADDR_MODE_CTRL][7:6] == $past(mode_entered))
        else $error("mode field not updated");
    AST_STOP_KEEP: assert property (mode_change && mode_entered == MODE_STOP |=> $stable(ctrl_q[ADDR_BUS_CTRL]))
        else $error("transceiver control changed on stop");
    AST_SLEEP_XCVR: assert property (mode_change && mode_entered == MODE_SLEEP
                                     |=> (ctrl_q[ADDR_BUS_CTRL] & 8'h0a) == 8'h00)
        else $error("transceiver left active on sleep");
    AST_RESTART_CLEAR: assert property (mode_change && mode_entered == MODE_RESTART |=> ctrl_q[ADDR_HS_CTRL_1] == 8'h00
        && ctrl_q[ADDR_HS_CTRL_2] == 8'h00 && (ctrl_q[ADDR_SUPPLY_CTRL] & SECOND_SUPPLY_MASK) == 8'h00)
        else $error("switch or supply config kept on restart");
    // Fail output is sticky until cleared
    AST_FAIL_HOLD: assert property (fail_trigger || (fail_output && !fail_clear) |=> fail_output)
        else $error("fail output dropped");
    AST_FAIL_DROP: assert property (fail_clear && !fail_trigger |=> !fail_output)
        else $error("fail output not cleared");

    CVR_SLEEP: cover property (mode_change && mode_entered == MODE_SLEEP);
    CVR_FRAME_END: cover property ($fell(sdo_oe));
    CVR_RESTART_FRAME: cover property (restart_mode && sdo_oe && sdo);
endmodule

bind sbc_spi_regs sbc_spi_regs_checker u_chk (
    .clk(clk), .rst_b(rst_b), .spi_pins(spi_pins), .sdo(sdo), .sdo_oe(sdo_oe),
    .restart_mode(restart_mode), .mode_change(mode_change), .mode_entered(mode_entered),
    .write_prohibited(write_prohibited), .stat_event(stat_event), .wake_pin_level(wake_pin_level),
    .fail_trigger(fail_trigger), .fail_clear(fail_clear), .ctrl_q(ctrl_q),
    .hs_drive_enable(hs_drive_enable), .fail_output(fail_output)
);

`default_nettype wire

// >>> verification/sbc_spi_regs_tb.sv
/*
 Self-checking bench: frames through the host model, register and
 summary expectations, mode-change edits. Assumes 200 MHz clk.
*/
`default_nettype none

module sbc_spi_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sbc_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identifier value
    localparam int SUM_POS [NSTAT] = '{5, 0, 1, 2, 3, 4, 4, 6, 7};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sbc_pins_t pins;
    logic sdo, sdo_oe, mode_change, write_prohibited, fail_trigger, fail_clear, fail_output;
    logic restart_mode;
    sbc_mode_t mode_entered;
    logic [NSTAT-1:0][7:0] stat_event;
    logic [NCTRL-1:0][7:0] ctrl_q;
    logic [7:0] wake_pin_level, hs_drive_enable;
    int fails = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    sbc_spi_regs #(.FAMILY_ID(ID_VAL)) DUT (
        .clk(clk), .rst_b(rst_b), .spi_pins(pins), .sdo(sdo), .sdo_oe(sdo_oe),
        .restart_mode(restart_mode), .mode_change(mode_change), .mode_entered(mode_entered),
        .write_prohibited(write_prohibited), .stat_event(stat_event), .wake_pin_level(wake_pin_level),
        .fail_trigger(fail_trigger), .fail_clear(fail_clear), .ctrl_q(ctrl_q),
        .hs_drive_enable(hs_drive_enable), .fail_output(fail_output)
    );

    sbc_host_model host (.clk(clk), .pins(pins), .sdo(sdo), .sdo_oe(sdo_oe));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_byte(nm, {7'h00, e}, {7'h00, g});
    endtask

    // One frame; error flag always checked, summary and byte only for full-length frames
    task automatic xfer(input logic [6:0] a, input logic b7, input logic [7:0] d, input int n,
                        input logic e_err, input logic [7:0] e_sum, input logic [7:0] e_dat);
        logic [15:0] rx;
        logic        err;
        host.frame({d, b7, a}, n, rx, err);
        chk_bit("error flag", e_err, err);
        if (n == 16)
        begin
            chk_byte("summary", e_sum, rx[7:0]);
            chk_byte("read byte", e_dat, rx[15:8]);
        end
    endtask

    task automatic set_mode(input sbc_mode_t m);
        mode_entered <= m;
        mode_change <= 1'b1;
        @(posedge clk);
        mode_change <= 1'b0;
        repeat (2) @(posedge clk);
        chk_byte("mode bits", {6'h00, m}, {6'h00, ctrl_q[ADDR_MODE_CTRL][7:6]});
    endtask

    task automatic pulse_stat(input int i, input logic [7:0] v);
        stat_event[i] <= v;
        @(posedge clk);
        stat_event[i] <= 8'h00;
        repeat (3) @(posedge clk);
    endtask

    // Watchdog: whole sequence needs about 12k cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        results();
    end

    initial
    begin
        {restart_mode, mode_change, write_prohibited, fail_trigger, fail_clear} = 5'h00;
        mode_entered = MODE_NORMAL;
        stat_event = '0;
        wake_pin_level = 8'h00;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        // Write, old byte returned, new byte on next frame
        xfer(ADDR_HS_CTRL_1, 1'b1, 8'h0f, 16, 1'b0, 8'h00, 8'h00);
        chk_byte("switch control", 8'h0f, ctrl_q[ADDR_HS_CTRL_1]);
        xfer(ADDR_HS_CTRL_1, 1'b0, 8'hf0, 16, 1'b0, 8'h00, 8'h0f);
        xfer(ADDR_HS_CTRL_1, 1'b0, 8'h00, 16, 1'b0, 8'h00, 8'h0f);
        chk_byte("switch drive", 8'h0f, hs_drive_enable);
        // Each status register: kept, mapped in summary, cleared
        for (int i = 0; i < NSTAT; i++)
        begin
            pulse_stat(i, 8'h81);
            if (i >= SI_HSOC)
                chk_byte("switch drive", 8'h0e, hs_drive_enable);
            xfer(STAT_ADDR[i], 1'b0, 8'h00, 16, 1'b0, 8'h01 << SUM_POS[i], 8'h81);
            xfer(STAT_ADDR[i], 1'b1, 8'h00, 16, 1'b0, 8'h01 << SUM_POS[i], 8'h81);
            xfer(STAT_ADDR[i], 1'b0, 8'h00, 16, 1'b0, 8'h00, 8'h00);
        end
        // Live levels and identifier refuse clears, stay out of summary
        wake_pin_level <= 8'hc3;
        xfer(ADDR_WAKE_LEVEL, 1'b1, 8'h00, 16, 1'b0, 8'h00, 8'hc3);
        xfer(ADDR_WAKE_LEVEL, 1'b0, 8'h00, 16, 1'b0, 8'h00, 8'hc3);
        xfer(ADDR_FAMILY_ID, 1'b1, 8'h00, 16, 1'b0, 8'h00, ID_VAL);
        // Short frames discarded and flagged; empty frame checks the flag
        xfer(ADDR_HS_CTRL_1, 1'b1, 8'h55, 8, 1'b0, 8'h00, 8'h00);
        xfer(ADDR_HS_CTRL_1, 1'b0, 8'h00, 16, 1'b1, 8'h00, 8'h0f);
        xfer(ADDR_HS_CTRL_1, 1'b1, 8'h55, 8, 1'b0, 8'h00, 8'h00);
        xfer(ADDR_HS_CTRL_1, 1'b0, 8'h00, 0, 1'b1, 8'h00, 8'h00);
        xfer(ADDR_HS_CTRL_1, 1'b0, 8'h00, 0, 1'b0, 8'h00, 8'h00);
        // Refused write leaves control, sets command-fail bit
        write_prohibited <= 1'b1;
        xfer(ADDR_HS_CTRL_1, 1'b1, 8'h33, 16, 1'b0, 8'h00, 8'h0f);
        write_prohibited <= 1'b0;
        chk_byte("switch control", 8'h0f, ctrl_q[ADDR_HS_CTRL_1]);
        xfer(STAT_ADDR[SI_DEV], 1'b1, 8'h00, 16, 1'b0, 8'h04, 8'h08);
        // Mode changes
        xfer(ADDR_BUS_CTRL, 1'b1, 8'h0e, 16, 1'b0, 8'h00, 8'h00);
        fail_trigger <= 1'b1;
        @(posedge clk);
        fail_trigger <= 1'b0;
        set_mode(MODE_STOP);
        chk_byte("bus control", 8'h0e, ctrl_q[ADDR_BUS_CTRL]);
        set_mode(MODE_SLEEP);
        chk_byte("bus control", 8'h05, ctrl_q[ADDR_BUS_CTRL]);
        chk_bit("fail output", 1'b1, fail_output);
        chk_byte("switch control", 8'h0f, ctrl_q[ADDR_HS_CTRL_1]);
        set_mode(MODE_NORMAL);
        xfer(ADDR_SUPPLY_CTRL, 1'b1, 8'h07, 16, 1'b0, 8'h00, 8'h00);
        set_mode(MODE_RESTART);
        chk_byte("switch control", 8'h00, ctrl_q[ADDR_HS_CTRL_1]);
        chk_byte("supply control", 8'h04, ctrl_q[ADDR_SUPPLY_CTRL]);
        chk_bit("fail output", 1'b1, fail_output);
        // Frames in restart are ignored and flagged afterwards
        restart_mode <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(ADDR_HS_CTRL_2, 1'b1, 8'h66, 16, 1'b1, 8'hff, 8'hff);
        restart_mode <= 1'b0;
        repeat (4) @(posedge clk);
        xfer(ADDR_HS_CTRL_2, 1'b0, 8'h00, 16, 1'b1, 8'h00, 8'h00);
        fail_clear <= 1'b1;
        @(posedge clk);
        fail_clear <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit("fail output", 1'b0, fail_output);
        results();
    end
endmodule

`default_nettype wire
